// File: hdl/function_output_control.sv
// Function-output control: coupler drive, auto decoupling, servo, sensors, lamps.
// Assumes an AXI4-Lite master on aclk; keys and analogue flag come from aclk logic.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "fo_defs.svh"

module function_output_control
    import fo_pkg::*;
#(
    parameter int unsigned COUPLER_FULL_CYC = `COUPLER_FULL_CYC,
    parameter int unsigned SERVO_TICK_CYC   = `SERVO_TICK_CYC,
    parameter int unsigned DC_UNIT_CYC      = `DC_UNIT_CYC,
    parameter int unsigned PULSE_GAP_CYC    = `PULSE_GAP_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output      logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output      logic        s_axi_wready,
    output      logic [1:0]  s_axi_bresp,
    output      logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output      logic        s_axi_arready,
    output      logic [31:0] s_axi_rdata,
    output      logic [1:0]  s_axi_rresp,
    output      logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [15:0] func_keys,
    input  wire logic        direction_fwd,
    input  wire logic        analog_mode,
    input  wire logic [3:0]  sensor_pins,
    input  wire logic        aux_output_nine_in,
    output      logic        aux_output_nine_out,
    output      logic        aux_output_nine_oe_n,
    output      logic        coupler_out,
    output      motion_t     motion,
    output      lamps_t      lamps,
    output      logic [5:0]  servo_position,
    output      logic        servo_pins_enable
);
    state_t      q;
    state_t      d;
    cfg_t        nc;
    logic        wr_go;
    logic        ar_go;
    logic        wok;
    logic        rok;
    logic [31:0] rdat;
    logic [9:0]  widx;
    logic [9:0]  ridx;
    logic        pmode;
    logic        k1;
    logic [15:0] base;
    logic [15:0] eff;
    logic [4:0]  sens;
    logic        key_c;
    logic        dc_en;
    logic        cpl_act;
    logic        swiss;
    logic        bank_aux;
    logic        bank_map;
    logic [5:0]  tgt;
    logic [7:0]  rt;

    // Both halves of a write must be present; one write in flight keeps it simple
    assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
    assign ar_go         = s_axi_arvalid & ~q.rvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = ~q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign widx          = s_axi_awaddr[11:2];
    assign ridx          = s_axi_araddr[11:2];

    assign bank_aux = (q.cfg.sel_pri == `BANK_PRI) && (q.cfg.sel_sec == `BANK_AUX);
    assign bank_map = (q.cfg.sel_pri == `BANK_PRI) && (q.cfg.sel_sec == `BANK_MAP);

    assign pmode = q.cfg.mode[`BIT_PULSE_MODE];
    assign k1    = func_keys[`KEY_ONE];
    // Sensor five only counts while the shared pin is released to the wheel sensor
    assign sens  = {q.s2[4] & q.cfg.options[`BIT_WHEEL_EN], q.s2[3:0]};
    assign base  = pmode ? ((func_keys & ~16'h0002) | q.pkeys) : func_keys;
    assign eff   = base
                 | (analog_mode ? {q.cfg.preset_hi[7:1], q.cfg.preset_lo, q.cfg.preset_hi[0]}
                                : 16'h0000)
                 | {sens, 11'h000};
    assign key_c   = eff[`KEY_COUPLER];
    assign dc_en   = q.cfg.dc_speed != 8'h00;
    assign cpl_act = dc_en ? (q.st == ST_PUSH || q.st == ST_PULL) : key_c;
    assign swiss   = (q.cfg.map_aux_output_one == `SWISS_AUX_OUTPUT_ONE) && (q.cfg.map_light == `SWISS_LIGHT);
    assign tgt     = eff[`KEY_SERVO] ? q.cfg.servo_b : q.cfg.servo_a;
    assign rt      = eff[`KEY_SERVO] ? q.cfg.run_b : q.cfg.run_a;

    assign coupler_out       = q.cpl_o;
    assign motion            = q.mo;
    assign lamps             = q.lo;
    assign aux_output_nine_out          = q.lo.aux_output_nine;
    assign aux_output_nine_oe_n         = q.cfg.options[`BIT_WHEEL_EN];
    assign servo_position    = q.pos;
    assign servo_pins_enable = ~q.cfg.options[`BIT_SUSI_EN];

    always_comb begin
        d    = q;
        nc   = q.cfg;
        wok  = 1'b1;
        rok  = 1'b1;
        rdat = 32'h0000_0000;

        // Register writes
        case (widx)
            `IDX_PRESET_LO: nc.preset_lo = s_axi_wdata[7:0];
            `IDX_PRESET_HI: nc.preset_hi = s_axi_wdata[7:0];
            `IDX_SEL_PRI:   nc.sel_pri   = s_axi_wdata[7:0];
            `IDX_SEL_SEC:   nc.sel_sec   = s_axi_wdata[7:0];
            `IDX_MODE:      nc.mode      = s_axi_wdata[7:0];
            `IDX_OPTIONS:   nc.options   = s_axi_wdata[7:0];
            `IDX_DC_SPEED:  nc.dc_speed  = s_axi_wdata[7:0];
            `IDX_DC_PULL:   nc.dc_pull   = s_axi_wdata[7:0];
            `IDX_DC_PUSH:   nc.dc_push   = s_axi_wdata[7:0];
            `IDX_LEVEL:     nc.level     = s_axi_wdata[4:0];
            `IDX_SERVO_A:   nc.servo_a   = s_axi_wdata[5:0];
            `IDX_SERVO_B:   nc.servo_b   = s_axi_wdata[5:0];
            `IDX_RUN_A:     nc.run_a     = s_axi_wdata[7:0];
            `IDX_RUN_B:     nc.run_b     = s_axi_wdata[7:0];
            `IDX_STATUS:    wok          = 1'b1;
            `IDX_MAP_AUX_OUTPUT_ONE:  if (bank_map) nc.map_aux_output_one = s_axi_wdata[7:0];
            `IDX_MAP_LIGHT: if (bank_map) nc.map_light = s_axi_wdata[7:0];
            `IDX_AUX_OUTPUT_NINE_CFG:  if (bank_aux) nc.aux_output_nine_cfg = s_axi_wdata[7:0];
            default:        wok          = 1'b0;
        endcase
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_go) begin
            d.bvalid = 1'b1;
            d.bresp  = wok ? `RESP_OKAY : `RESP_SLVERR;
            if (s_axi_wstrb[0]) begin
                d.cfg = nc;
            end
        end

        // Register reads; other banks of the indexed window read zero
        case (ridx)
            `IDX_PRESET_LO: rdat[7:0] = q.cfg.preset_lo;
            `IDX_PRESET_HI: rdat[7:0] = q.cfg.preset_hi;
            `IDX_SEL_PRI:   rdat[7:0] = q.cfg.sel_pri;
            `IDX_SEL_SEC:   rdat[7:0] = q.cfg.sel_sec;
            `IDX_MODE:      rdat[7:0] = q.cfg.mode;
            `IDX_OPTIONS:   rdat[7:0] = q.cfg.options;
            `IDX_DC_SPEED:  rdat[7:0] = q.cfg.dc_speed;
            `IDX_DC_PULL:   rdat[7:0] = q.cfg.dc_pull;
            `IDX_DC_PUSH:   rdat[7:0] = q.cfg.dc_push;
            `IDX_LEVEL:     rdat[4:0] = q.cfg.level;
            `IDX_SERVO_A:   rdat[5:0] = q.cfg.servo_a;
            `IDX_SERVO_B:   rdat[5:0] = q.cfg.servo_b;
            `IDX_RUN_A:     rdat[7:0] = q.cfg.run_a;
            `IDX_RUN_B:     rdat[7:0] = q.cfg.run_b;
            `IDX_STATUS:    rdat[15:0] = {q.cpl_o, q.pcount, q.st, q.pos, 1'b0};
            `IDX_MAP_AUX_OUTPUT_ONE:  if (bank_map) rdat[7:0] = q.cfg.map_aux_output_one;
            `IDX_MAP_LIGHT: if (bank_map) rdat[7:0] = q.cfg.map_light;
            `IDX_AUX_OUTPUT_NINE_CFG:  if (bank_aux) rdat[7:0] = q.cfg.aux_output_nine_cfg;
            default:        rok = 1'b0;
        endcase
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (ar_go) begin
            d.rvalid = 1'b1;
            d.rdata  = rdat;
            d.rresp  = rok ? `RESP_OKAY : `RESP_SLVERR;
        end

        // Pin synchronisers
        d.s1 = {aux_output_nine_in, sensor_pins};
        d.s2 = q.s1;

        // Pulse sequence: presses counted, a quiet gap commits the count
        d.k1prev = k1;
        if (!pmode) begin
            d.pcount = 4'h0;
            d.gap    = 32'h0;
        end else if (k1 && !q.k1prev) begin
            d.gap = 32'h0;
            if (q.pcount != 4'hf) begin
                d.pcount = q.pcount + 4'h1;
            end
        end else if (q.pcount != 4'h0) begin
            if (q.gap >= PULSE_GAP_CYC - 1) begin
                d.pkeys[q.pcount] = ~q.pkeys[q.pcount];
                d.pcount          = 4'h0;
                d.gap             = 32'h0;
            end else begin
                d.gap = q.gap + 32'h1;
            end
        end

        // Decoupling sequence
        case (q.st)
            ST_IDLE: begin
                if (key_c && dc_en) begin
                    d.st    = ST_PUSH;
                    d.units = q.cfg.dc_push;
                    d.tcnt  = 32'h0;
                end
            end
            ST_PUSH, ST_PULL: begin
                if (q.units == 8'h00) begin
                    d.tcnt = 32'h0;
                    if (q.st == ST_PUSH) begin
                        d.st    = ST_PULL;
                        d.units = q.cfg.dc_pull;
                    end else begin
                        d.st = ST_DONE;
                    end
                end else if (q.tcnt >= DC_UNIT_CYC - 1) begin
                    d.tcnt  = 32'h0;
                    d.units = q.units - 8'h01;
                end else begin
                    d.tcnt = q.tcnt + 32'h1;
                end
            end
            ST_DONE: begin
                if (!key_c) begin
                    d.st = ST_IDLE;
                end
            end
            default: d.st = ST_IDLE;
        endcase
        d.mo.active  = (d.st == ST_PUSH) || (d.st == ST_PULL);
        d.mo.reverse = d.st == ST_PUSH;
        d.mo.speed   = d.mo.active ? q.cfg.dc_speed : 8'h00;

        // Coupler drive: full power for COUPLER_FULL_CYC first, then PWM at the set level protects the coil
        d.cprev = cpl_act;
        if (cpl_act && !q.cprev) begin
            d.full = 32'(COUPLER_FULL_CYC);
        end else if (!cpl_act) begin
            d.full = 32'h0;
        end else if (q.full != 32'h0) begin
            d.full = q.full - 32'h1;
        end
        if (q.pdiv >= `PWM_DIV - 5'd1) begin
            d.pdiv  = 5'd0;
            d.pstep = (q.pstep >= `PWM_STEPS - 5'd1) ? 5'd0 : q.pstep + 5'd1;
        end else begin
            d.pdiv = q.pdiv + 5'd1;
        end
        d.cpl_o = cpl_act && (q.full != 32'h0 || q.pstep < q.cfg.level);

        // Servo: one position step per run-time count of base ticks
        if (q.stick >= SERVO_TICK_CYC - 1) begin
            d.stick = 32'h0;
            if (q.pos == tgt) begin
                d.scnt = 8'h00;
            end else if ({1'b0, q.scnt} + 9'd1 >= {1'b0, rt}) begin
                d.scnt = 8'h00;
                d.pos  = (q.pos < tgt) ? q.pos + 6'd1 : q.pos - 6'd1;
            end else begin
                d.scnt = q.scnt + 8'h01;
            end
        end else begin
            d.stick = q.stick + 32'h1;
        end

        // Lamps and auxiliary outputs
        d.lo.head_fwd = eff[`KEY_LIGHT] & direction_fwd;
        d.lo.head_rev = eff[`KEY_LIGHT] & ~direction_fwd;
        d.lo.aux_output_one     = eff[`KEY_ONE] | (swiss & eff[`KEY_LIGHT]);
        d.lo.aux_output_nine     = eff[`KEY_AUX_OUTPUT_NINE] & (q.cfg.aux_output_nine_cfg != 8'h00);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q               <= '0;
            q.st            <= ST_IDLE;
            q.cfg.preset_lo <= `RST_PRESET_LO;
            q.cfg.preset_hi <= `RST_PRESET_HI;
            q.cfg.aux_output_nine_cfg  <= `RST_AUX_OUTPUT_NINE_CFG;
            q.cfg.level     <= `RST_LEVEL;
            q.cfg.servo_b   <= `RST_SERVO_B;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_push_entry;
        (q.st == ST_IDLE) ##1 (q.st == ST_PUSH);
    endsequence

    sequence s_pull_entry;
        (q.st == ST_PUSH) ##1 (q.st == ST_PULL);
    endsequence

    property p_full_on;
        cpl_act && $past(cpl_act) && q.full != 32'h0 |=> coupler_out;
    endproperty
    a_full_on: assert property (p_full_on) else $error("coupler not full on");

    property p_level_off;
        cpl_act && q.full == 32'h0 && q.cfg.level == 5'd0 |=> !coupler_out;
    endproperty
    a_level_off: assert property (p_level_off) else $error("level zero drives");

    property p_push_first;
        s_push_entry |-> motion.reverse && motion.active && q.units == $past(q.cfg.dc_push);
    endproperty
    a_push_first: assert property (p_push_first) else $error("bad push entry");

    property p_disabled;
        q.st == ST_IDLE && q.cfg.dc_speed == 8'h00 |=> q.st == ST_IDLE && !motion.active;
    endproperty
    a_disabled: assert property (p_disabled) else $error("zero speed moved");

    property p_pull_load;
        s_pull_entry |-> !motion.reverse && q.units == $past(q.cfg.dc_pull);
    endproperty
    a_pull_load: assert property (p_pull_load) else $error("bad pull entry");

    property p_wheel;
        q.cfg.options[`BIT_WHEEL_EN] |-> aux_output_nine_oe_n;
    endproperty
    a_wheel: assert property (p_wheel) else $error("aux nine driven");

    property p_analog;
        analog_mode && q.cfg.preset_lo[0] && !pmode |=> lamps.aux_output_one;
    endproperty
    a_analog: assert property (p_analog) else $error("preset not pressed");

    property p_swiss;
        swiss && func_keys[`KEY_LIGHT] |=> lamps.aux_output_one ##0 (lamps.head_fwd || lamps.head_rev);
    endproperty
    a_swiss: assert property (p_swiss) else $error("aux one not lit");

    property p_done_hold;
        q.st == ST_DONE && key_c |=> q.st == ST_DONE && motion.speed == 8'h00;
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("restarted early");

endmodule // function_output_control

// File: pkg/fo_defs.svh
// Register indices, reset values and timing counts of the function-output block.
// Assumes a 20 MHz aclk and an AXI4-Lite master with 12-bit byte addresses.
// How it works
// - Coupler output full on 250 ms, then PWM
// - Coupler duty follows level: 0 off, 31 on
// - Decoupling pushes backwards first, then pulls away
// - Decoupling speed register; zero disables decoupling
// - Pull-away phase length from pull time
// - Push phase length from push time
// - Servo run times A/B in 0.25 s units
// - Servo end positions A and B from settings
// - Servo five/six pins usable only with SUSI off
// - Five sensor inputs can trigger functions
// - Shared pin is wheel sensor when bit 4 set
// - Analogue mode presses the preset function keys
// - Preset bits map to keys F1-F8, F0, F9-F15
// - Defaults press lighting key and key one
// - Count key-one presses, toggle the counted function
// - Values 5 and 6 tie aux one to lights
// - Index selectors choose the bank of indexed variables
`ifndef FO_DEFS_SVH
`define FO_DEFS_SVH

`define IDX_PRESET_LO   10'h00d
`define IDX_PRESET_HI   10'h00e
`define IDX_SEL_PRI     10'h01f
`define IDX_SEL_SEC     10'h020
`define IDX_MODE        10'h031
`define IDX_OPTIONS     10'h07c
`define IDX_DC_SPEED    10'h0f6
`define IDX_DC_PULL     10'h0f7
`define IDX_DC_PUSH     10'h0f8
`define IDX_LEVEL       10'h100
`define IDX_SERVO_A     10'h101
`define IDX_SERVO_B     10'h102
`define IDX_RUN_A       10'h103
`define IDX_RUN_B       10'h104
`define IDX_STATUS      10'h105
`define IDX_MAP_AUX_OUTPUT_ONE    10'h14a
`define IDX_AUX_OUTPUT_NINE_CFG    10'h153
`define IDX_MAP_LIGHT   10'h15a

`define BANK_PRI        8'h10
`define BANK_AUX        8'h00
`define BANK_MAP        8'h02
`define SWISS_AUX_OUTPUT_ONE      8'h05
`define SWISS_LIGHT     8'h06

`define BIT_SUSI_EN     3
`define BIT_WHEEL_EN    4
`define BIT_PULSE_MODE  5
`define KEY_LIGHT       0
`define KEY_ONE         1
`define KEY_COUPLER     4
`define KEY_SERVO       5
`define KEY_AUX_OUTPUT_NINE        9

`define RST_PRESET_LO   8'h01
`define RST_PRESET_HI   8'h01
`define RST_AUX_OUTPUT_NINE_CFG    8'h01
`define RST_LEVEL       5'h10
`define RST_SERVO_B     6'h3f
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`define CLK_HZ          20000000
`define COUPLER_FULL_MS 250
`define COUPLER_FULL_CYC (`COUPLER_FULL_MS * (`CLK_HZ / 1000))
`define SERVO_UNIT_MS   250
`define SERVO_STEPS     64
`define SERVO_TICK_CYC  ((`SERVO_UNIT_MS * (`CLK_HZ / 1000)) / `SERVO_STEPS)
`define DC_UNIT_MS      100
`define DC_UNIT_CYC     (`DC_UNIT_MS * (`CLK_HZ / 1000))
`define PULSE_GAP_MS    1000
`define PULSE_GAP_CYC   (`PULSE_GAP_MS * (`CLK_HZ / 1000))
`define PWM_DIV         5'd31
`define PWM_STEPS       5'd31

`endif

// File: pkg/fo_pkg.sv
// Types of the function-output block: decoupling states, carriers, state record.
// Assumes fo_defs.svh supplies the numeric constants.
package fo_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_PUSH = 4'b0010,
        ST_PULL = 4'b0100,
        ST_DONE = 4'b1000
    } dc_state_t;

    typedef struct packed {
        logic       active;
        logic       reverse;
        logic [7:0] speed;
    } motion_t;

    typedef struct packed {
        logic head_fwd;
        logic head_rev;
        logic aux_output_one;
        logic aux_output_nine;
    } lamps_t;

    typedef struct packed {
        logic [7:0] preset_lo, preset_hi, dc_speed, dc_pull, dc_push;
        logic [7:0] options, mode, sel_pri, sel_sec, map_aux_output_one, map_light, aux_output_nine_cfg;
        logic [7:0] run_a, run_b;
        logic [5:0] servo_a, servo_b;
        logic [4:0] level;
    } cfg_t;

    typedef struct packed {
        cfg_t        cfg;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        dc_state_t   st;
        logic [31:0] tcnt;
        logic [7:0]  units;
        logic        cprev;
        logic [31:0] full;
        logic [4:0]  pdiv;
        logic [4:0]  pstep;
        logic        cpl_o;
        logic [5:0]  pos;
        logic [31:0] stick;
        logic [7:0]  scnt;
        logic        k1prev;
        logic [3:0]  pcount;
        logic [31:0] gap;
        logic [15:0] pkeys;
        logic [4:0]  s1;
        logic [4:0]  s2;
        motion_t     mo;
        lamps_t      lo;
    } state_t;
endpackage

// File: test/fo_far_side.sv
// Far-side model: wheel sensor sharing the aux nine pin, sensor contacts.
// Assumes the device releases the shared pin by raising aux_output_nine_oe_n.
`timescale 1ns/1ns

module fo_far_side (
    input  wire logic       aclk,
    input  wire logic       aux_output_nine_out,
    input  wire logic       aux_output_nine_oe_n,
    input  wire logic       wheel_turning,
    output      logic       aux_output_nine_in,
    output      logic [3:0] sensor_pins
);
    logic wheel_q;

    initial wheel_q = 1'b0;

    // Released pin toggles while wheel_turning, else inverts aux_output_nine_out, so a stale level never passes for data
    always @(posedge aclk) begin
        wheel_q <= wheel_turning ? ~wheel_q : ~aux_output_nine_out;
    end

    assign aux_output_nine_in     = aux_output_nine_oe_n ? wheel_q : aux_output_nine_out;
    assign sensor_pins = 4'h0;
endmodule // fo_far_side

// File: test/test_decoder_function_output_control.sv
// Bench of the function-output block: AXI4-Lite tasks and port checks.
// Assumes shortened counts via parameters and a 50 ns aclk.
`timescale 1ns/1ns
`include "fo_defs.svh"

module test_decoder_function_output_control
    import fo_pkg::*;
;
    localparam int CF = 16;
    localparam int DU = 8;
    localparam int PG = 20;
    logic        aclk, aresetn, direction_fwd, analog_mode, wheel_turning, aux_output_nine_in;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, aux_output_nine_out, aux_output_nine_oe_n, coupler_out;
    logic        servo_pins_enable;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, sensor_pins;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [15:0] func_keys;
    logic [5:0]  servo_position;
    motion_t     motion;
    lamps_t      lamps;
    int          fail_count, n_compared, n, rv, fw, first, spd;

    function_output_control #(.COUPLER_FULL_CYC(CF), .SERVO_TICK_CYC(4),
        .DC_UNIT_CYC(DU), .PULSE_GAP_CYC(PG)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .func_keys, .direction_fwd, .analog_mode, .sensor_pins, .aux_output_nine_in,
        .aux_output_nine_out, .aux_output_nine_oe_n, .coupler_out, .motion, .lamps, .servo_position,
        .servo_pins_enable);

    fo_far_side u_far (.aclk, .aux_output_nine_out, .aux_output_nine_oe_n, .wheel_turning, .aux_output_nine_in,
        .sensor_pins);

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tk(input int c);
        repeat (c) @(posedge aclk);
    endtask

    // Both channels offered together; bready and rready stay high throughout
    task automatic wr(input logic [9:0] i, input logic [31:0] d, input logic [1:0] r);
        s_axi_awaddr  <= {i, 2'b00};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do @(posedge aclk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
    endtask

    task automatic rd(input logic [9:0] i, input logic [31:0] e, input logic [1:0] r);
        s_axi_araddr  <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
    endtask

    task automatic hi(input int c);
        n = 0;
        repeat (c) begin
            @(negedge aclk);
            n += (coupler_out === 1'b1);
        end
        @(posedge aclk);
    endtask

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    initial begin
        #(50 * 20000);
        fail_count++;
        close_out();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, analog_mode} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, func_keys} = '0;
        {direction_fwd, wheel_turning} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = '1;
        tk(20);
        aresetn <= 1'b1;
        rd(`IDX_PRESET_LO, 32'h01, `RESP_OKAY);
        rd(`IDX_PRESET_HI, 32'h01, `RESP_OKAY);
        rd(`IDX_DC_SPEED, 32'h00, `RESP_OKAY);
        rd(10'h3ff, 32'h00, `RESP_SLVERR);
        wr(10'h3ff, 32'h5a, `RESP_SLVERR);
        wr(`IDX_LEVEL, 32'h00, `RESP_OKAY);
        func_keys[4] <= 1'b1;
        hi(200);
        chk("full on cycles", CF, n);
        chk("motion idle", 0, motion.active);
        wr(`IDX_LEVEL, 32'h1f, `RESP_OKAY);
        tk(4);
        hi(100);
        chk("level 31 on", 100, n);
        wr(`IDX_LEVEL, 32'h10, `RESP_OKAY);
        tk(40);
        hi(961);
        chk("level 16 on", 496, n);
        func_keys[4] <= 1'b0;
        wr(`IDX_DC_SPEED, 32'h03, `RESP_OKAY);
        wr(`IDX_DC_PUSH, 32'h01, `RESP_OKAY);
        wr(`IDX_DC_PULL, 32'hffffff02, `RESP_OKAY);
        rd(`IDX_DC_PULL, 32'h02, `RESP_OKAY);
        repeat (2) begin
            func_keys[4] <= 1'b1;
            {rv, fw} = '0;
            first = 2;
            repeat (60) begin
                @(negedge aclk);
                if (motion.active === 1'b1) begin
                    if (first == 2)
                        {first, spd} = {31'h0, motion.reverse, 24'h0, motion.speed};
                    rv += motion.reverse;
                    fw += !motion.reverse;
                end
            end
            chk("first reverse", 1, first);
            chk("speed", 3, spd);
            chk("push length", 1, rv inside {[DU : DU + 1]});
            chk("pull length", 1, fw inside {[2 * DU : 2 * DU + 2]});
            chk("stopped", 0, motion.active);
            @(posedge aclk);
            func_keys[4] <= 1'b0;
            tk(3);
        end
        wr(`IDX_DC_SPEED, 32'h00, `RESP_OKAY);
        wr(`IDX_LEVEL, 32'h1f, `RESP_OKAY);
        direction_fwd <= 1'b1;
        analog_mode   <= 1'b1;
        tk(4);
        chk("analogue headlight", 1, lamps.head_fwd);
        wr(`IDX_PRESET_LO, 32'h08, `RESP_OKAY);
        tk(30);
        hi(10);
        chk("analogue key four", 10, n);
        wr(`IDX_PRESET_HI, 32'h00, `RESP_OKAY);
        tk(3);
        chk("analogue light off", 0, lamps.head_fwd);
        analog_mode <= 1'b0;
        chk("servo pins", 1, servo_pins_enable);
        func_keys[9] <= 1'b1;
        wr(`IDX_OPTIONS, 32'h08, `RESP_OKAY);
        tk(2);
        chk("servo pins", 0, servo_pins_enable);
        chk("aux nine on", 1, aux_output_nine_out);
        wr(`IDX_SEL_PRI, 32'h10, `RESP_OKAY);
        wr(`IDX_SEL_SEC, 32'h00, `RESP_OKAY);
        wr(`IDX_AUX_OUTPUT_NINE_CFG, 32'h00, `RESP_OKAY);
        wr(`IDX_OPTIONS, 32'h10, `RESP_OKAY);
        wheel_turning <= 1'b1;
        tk(2);
        chk("aux nine released", 1, aux_output_nine_oe_n);
        chk("servo pins", 1, servo_pins_enable);
        wr(`IDX_OPTIONS, 32'h00, `RESP_OKAY);
        tk(2);
        chk("aux nine driven", 0, aux_output_nine_oe_n);
        chk("aux nine off", 0, aux_output_nine_out);
        wr(`IDX_SEL_SEC, 32'h02, `RESP_OKAY);
        wr(`IDX_MAP_AUX_OUTPUT_ONE, 32'h05, `RESP_OKAY);
        wr(`IDX_MAP_LIGHT, 32'h06, `RESP_OKAY);
        rd(`IDX_MAP_AUX_OUTPUT_ONE, 32'h05, `RESP_OKAY);
        direction_fwd <= 1'b0;
        func_keys[0]  <= 1'b1;
        tk(3);
        chk("aux one on", 1, lamps.aux_output_one);
        chk("head reverse", 1, lamps.head_rev);
        func_keys[0] <= 1'b0;
        tk(3);
        chk("aux one off", 0, lamps.aux_output_one);
        wr(`IDX_SEL_SEC, 32'h00, `RESP_OKAY);
        rd(`IDX_MAP_AUX_OUTPUT_ONE, 32'h00, `RESP_OKAY);
        wr(`IDX_SERVO_A, 32'h05, `RESP_OKAY);
        wr(`IDX_RUN_A, 32'h01, `RESP_OKAY);
        tk(60);
        chk("servo at A", 5, servo_position);
        wr(`IDX_RUN_B, 32'h02, `RESP_OKAY);
        func_keys[5] <= 1'b1;
        tk(200);
        chk("servo travelling", 1, servo_position != 6'h3f);
        tk(400);
        chk("servo at B", 63, servo_position);
        wr(`IDX_MODE, 32'h20, `RESP_OKAY);
        repeat (4) begin
            func_keys[1] <= 1'b1;
            tk(2);
            func_keys[1] <= 1'b0;
            tk(2);
        end
        tk(PG + 30);
        hi(10);
        chk("pulse count four", 10, n);
        close_out();
    end
endmodule // test_decoder_function_output_control
